// [pkg/cctg_pkg.sv]
// Purpose: Shared constants and types for the serial control-word receiver.
// Assumes: Control word is 72 bits, shifted in with bit 0 first.
// Notes: Timing counts derive from the 25 ns system clock period.
package cctg_pkg;
	// Word layout.
	localparam int WORD_W = 72;
	localparam int SEL_LSB = 0;
	localparam int SEL_W = 8;
	localparam int CAT_ROUTE_BIT = 8;
	localparam int SMD_LSB = 16;
	localparam int SMD_W = 2;
	localparam int FRM_LSB = 18;
	localparam int FRM_W = 8;
	localparam int LINES_LSB = 26;
	localparam int LINES_W = 10;
	localparam int RECORD_EXPOSURE_EN_BIT = 48;
	localparam int DRIVE_MODE_SEL_BIT = 51;
	localparam int SSG_BIT = 52;
	localparam int WEN_BIT = 53;
	localparam int CLP_BIT = 54;
	localparam int ID_BIT = 55;
	localparam int HMCK_BIT = 56;
	localparam int TMCK_BIT = 57;
	localparam int HREV_BIT = 58;
	localparam int TREV_BIT = 59;
	localparam int DSG_LSB = 60;
	localparam int DSG_W = 2;
	localparam int STB_LSB = 62;
	localparam int STB_W = 2;
	localparam int SUM_BYTES = 9;
	localparam int ADJ_LSB = 16;
	localparam int ADJ_W = 48;
	// Timing.
	localparam int CLK_PERIOD_NS = 25;
	localparam int FIELD_DLY_NS = 1100;
	localparam int FIELD_DLY_CYC = (FIELD_DLY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int DRIVE_GATE_NS = 100;
	localparam int DRIVE_GATE_CYC = DRIVE_GATE_NS / CLK_PERIOD_NS;
	localparam int FCNT_W = 8;

	// Drive level of a vertical or substrate output.
	typedef enum logic [1:0] {
		CCTG_LVL_LOW = 2'b00,
		CCTG_LVL_MID = 2'b01,
		CCTG_LVL_HIGH = 2'b10
	} cctg_lvl_e;

	// Applied control settings.
	typedef struct packed {
		logic [STB_W-1:0] pin_state_ctl;
		logic [DSG_W-1:0] pulse_gen_ctl;
		logic dsp_clock_reset_pol;
		logic half_rate_reset_pol;
		logic dsp_clock_off;
		logic half_rate_clock_on;
		logic line_tag_on;
		logic black_clamp_on;
		logic write_pulse_off;
		logic sync_gen_on;
		logic drive_mode_sel;
		logic record_exposure_en;
		logic [LINES_W-1:0] shutter_lines;
		logic [FRM_W-1:0] shutter_frames;
		logic [SMD_W-1:0] shutter_mode;
	} cctg_ctl_s;

	localparam cctg_ctl_s CTL_RESET = '0;
	localparam logic [ADJ_W-1:0] ADJ_RESET = '0;
endpackage : cctg_pkg

// [hdl/cctg_shift.sv]
// Purpose: Serial shift register on the host's serial clock.
// Assumes: Strobe is low while bits are shifted and high between words.
// Notes: The word holds still while the strobe is high, which lets the
// system clock side copy it after seeing the strobe rise.
`timescale 1ns/1ps
module cctg_shift #(
	parameter int WORD_W = cctg_pkg::WORD_W
) (
	// Link side.
	input wire logic serial_clock,
	input wire logic serial_data_in,
	input wire logic serial_strobe,
	// Received word.
	output logic [WORD_W-1:0] word_r
);
	// RQ1 rising edge sampling.
	// Shift in bit 0 first so it ends in the lowest position.
	always_ff @(posedge serial_clock) begin
		if (!serial_strobe) begin
			word_r <= {serial_data_in, word_r[WORD_W-1:1]};
		end
	end
endmodule : cctg_shift

// [hdl/cctg_top.sv]
// Purpose: Control-word receive, check and apply, field detect, drive gate.
// Assumes: rst_n is synchronous to clk; sync inputs follow sys_clock_780.
// Notes: Waveform shapes are simplified stand-ins derived from the 780 clock, the DSP clock from clk.
// Operation
// RQ1 - Sample serial data on serial clock rise
// RQ2 - Apply word at readout line hsync fall
// RQ3 - Readout line is vert 2a/2b readout
// RQ4 - Host holds strobe high at apply
// RQ5 - Sync enable, pin state apply at strobe
// RQ6 - Delayed hsync sample high means even
// RQ7 - Capture syncs on 780 clock rise
// RQ8 - Drive gate low forces pulses low
// RQ9 - Gate low: vertical, substrate at rails
// RQ10 - Write pulse, line tag change on 780
// RQ11 - Control and adjustment held separately
// RQ12 - Select byte then category byte
// RQ13 - Shutter mode, frames, lines fields
// RQ14 - Exposure enable and drive mode bits
// RQ15 - Output enable bits and polarities
// RQ16 - Reset polarity bits for two clocks
// RQ17 - Pulse control and pin state fields
// RQ18 - Checksum byte protects the word
// RQ19 - All control fields zero after reset
// RQ20 - Host sends an initialization word
// RQ21 - Host may send adjustment at start
// RQ22 - Accept only matching select code
// RQ23 - Category bit routes to register set
// RQ24 - Bypass input disables checksum check
// RQ25 - Active low reset holds device
// RQ26 - Reserved bits are ignored
// RQ27 - Delayed hsync sample low means odd
`timescale 1ns/1ps
module cctg_top #(
	parameter logic [7:0] CHIP_SELECT = 8'h99, // Arbitrary code, bits 0 and 7 set.
	parameter int MCK_HALF = 2,
	parameter int DSP_HALF = 1,
	parameter int LINE_W = 10,
	parameter logic [9:0] READOUT_LINE = 10'h004
) (
	// System clock and reset.
	input wire logic clk,
	input wire logic rst_n,
	// Serial link.
	input wire logic serial_clock,
	input wire logic serial_data_in,
	input wire logic serial_strobe,
	// Control pins.
	input wire logic check_bypass_in,
	input wire logic hsync_in,
	input wire logic vsync_in,
	input wire logic drive_gate_in,
	// Clocks and sync outputs.
	output logic sys_clock_780,
	output logic hsync_out,
	output logic vsync_out,
	output logic half_rate_pixel_clock,
	output logic dsp_clock_1170,
	output logic adc_clock_out,
	// Line outputs.
	output logic write_pulse_out,
	output logic line_tag_out,
	output logic black_clamp_pulse,
	output logic dummy_clamp_pulse,
	output logic blanking_pulse,
	// Sensor drive outputs.
	output logic horiz_clock_a,
	output logic horiz_clock_b,
	output logic reset_gate_pulse,
	output logic precharge_sample_pulse,
	output logic level_sample_pulse,
	output logic adc_phase_sample,
	output cctg_pkg::cctg_lvl_e vert_clock_2a,
	output cctg_pkg::cctg_lvl_e vert_clock_2b,
	output cctg_pkg::cctg_lvl_e vert_clock_1,
	output cctg_pkg::cctg_lvl_e vert_clock_3,
	output cctg_pkg::cctg_lvl_e substrate_pulse,
	// Register state.
	output cctg_pkg::cctg_ctl_s ctl_r,
	output logic [cctg_pkg::ADJ_W-1:0] adj_r,
	output logic field_even_r,
	output logic readout_r
);
	logic [cctg_pkg::WORD_W-1:0] word;
	logic [1:0] stb_s, hs_s, vs_s, dg_s, byp_s;
	logic stb_d_r, stb_rise, sum_ok, sel_ok, accept, is_adj, gate_off;
	logic [7:0] sum;
	cctg_pkg::cctg_ctl_s word_ctl, ctl_pend_r;
	logic ctl_pend_v_r, adj_pend_v_r, apply_now;
	logic [cctg_pkg::ADJ_W-1:0] adj_pend_r;
	logic [7:0] mck_cnt_r;
	logic mck_r, mck_rise;
	logic hs_cap_r, vs_cap_r, hs_fall_r, vs_fall_r;
	logic [LINE_W-1:0] line_r;
	logic [cctg_pkg::FCNT_W-1:0] fcnt_r;
	logic hrc_r, dsp_r, post_r;
	logic [7:0] dsp_cnt_r;

	// Serial shift register on the link clock.
	cctg_shift #(.WORD_W(cctg_pkg::WORD_W)) u_shift (
		.serial_clock(serial_clock),
		.serial_data_in(serial_data_in),
		.serial_strobe(serial_strobe),
		.word_r(word)
	);

	// RQ25 reset synchronisers.
	// Two-stage synchronisers for every pin sampled by clk.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			stb_s <= 2'h3;
			hs_s <= 2'h0;
			vs_s <= 2'h0;
			dg_s <= 2'h3;
			byp_s <= 2'h0;
		end else begin
			stb_s <= {stb_s[0], serial_strobe};
			hs_s <= {hs_s[0], hsync_in};
			vs_s <= {vs_s[0], vsync_in};
			dg_s <= {dg_s[0], drive_gate_in};
			byp_s <= {byp_s[0], check_bypass_in};
		end
	end

	// Strobe edge; the shift register is frozen while the strobe is high.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			stb_d_r <= 1'b1;
		end else begin
			stb_d_r <= stb_s[1];
		end
	end
	assign stb_rise = stb_s[1] & ~stb_d_r;

	// RQ18 checksum byte sum.
	// All nine bytes, check byte included, must sum to zero.
	always_comb begin
		sum = 8'h00;
		for (int i = 0; i < cctg_pkg::SUM_BYTES; i++) begin
			sum = sum + word[i*8 +: 8];
		end
	end
	assign sum_ok = (sum == 8'h00);

	// RQ12 select byte position.
	// RQ22 select code match.
	assign sel_ok = (word[cctg_pkg::SEL_LSB +: cctg_pkg::SEL_W] == CHIP_SELECT);
	// RQ24 checksum bypass.
	assign accept = stb_rise & sel_ok & (byp_s[1] | sum_ok);
	// RQ23 category routing.
	assign is_adj = word[cctg_pkg::CAT_ROUTE_BIT];

	// RQ13 shutter fields.
	// RQ14 exposure and drive mode.
	// RQ15 enable bits.
	// RQ16 polarity bits.
	// RQ17 pulse and pin fields.
	// RQ26 reserved bits dropped.
	// Unpack the received word into control fields.
	always_comb begin
		word_ctl.shutter_mode = word[cctg_pkg::SMD_LSB +: cctg_pkg::SMD_W];
		word_ctl.shutter_frames = word[cctg_pkg::FRM_LSB +: cctg_pkg::FRM_W];
		word_ctl.shutter_lines = word[cctg_pkg::LINES_LSB +: cctg_pkg::LINES_W];
		word_ctl.record_exposure_en = word[cctg_pkg::RECORD_EXPOSURE_EN_BIT];
		word_ctl.drive_mode_sel = word[cctg_pkg::DRIVE_MODE_SEL_BIT];
		word_ctl.sync_gen_on = word[cctg_pkg::SSG_BIT];
		word_ctl.write_pulse_off = word[cctg_pkg::WEN_BIT];
		word_ctl.black_clamp_on = word[cctg_pkg::CLP_BIT];
		word_ctl.line_tag_on = word[cctg_pkg::ID_BIT];
		word_ctl.half_rate_clock_on = word[cctg_pkg::HMCK_BIT];
		word_ctl.dsp_clock_off = word[cctg_pkg::TMCK_BIT];
		word_ctl.half_rate_reset_pol = word[cctg_pkg::HREV_BIT];
		word_ctl.dsp_clock_reset_pol = word[cctg_pkg::TREV_BIT];
		word_ctl.pulse_gen_ctl = word[cctg_pkg::DSG_LSB +: cctg_pkg::DSG_W];
		word_ctl.pin_state_ctl = word[cctg_pkg::STB_LSB +: cctg_pkg::STB_W];
	end

	// RQ4 strobe high at apply.
	// Apply only on the readout line hsync fall with the strobe high.
	assign apply_now = hs_fall_r & readout_r & stb_s[1];

	// RQ11 separate pending sets.
	// Pending words; a new accept wins over a same-cycle apply.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ctl_pend_r <= cctg_pkg::CTL_RESET;
			ctl_pend_v_r <= 1'b0;
			adj_pend_r <= cctg_pkg::ADJ_RESET;
			adj_pend_v_r <= 1'b0;
		end else begin
			if (apply_now) begin
				ctl_pend_v_r <= 1'b0;
				adj_pend_v_r <= 1'b0;
			end
			if (accept && !is_adj) begin
				ctl_pend_r <= word_ctl;
				ctl_pend_v_r <= 1'b1;
			end
			if (accept && is_adj) begin
				adj_pend_r <= word[cctg_pkg::ADJ_LSB +: cctg_pkg::ADJ_W];
				adj_pend_v_r <= 1'b1;
			end
		end
	end

	// RQ19 zero after reset.
	// Applied control set; immediate fields follow the strobe rise.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ctl_r <= cctg_pkg::CTL_RESET;
		end else begin
			// RQ2 line-synchronous apply.
			if (apply_now && ctl_pend_v_r) begin
				ctl_r <= ctl_pend_r;
			end
			// RQ5 immediate strobe apply.
			if (accept && !is_adj) begin
				ctl_r.sync_gen_on <= word_ctl.sync_gen_on;
				ctl_r.pin_state_ctl <= word_ctl.pin_state_ctl;
			end
		end
	end

	// Applied adjustment set.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			adj_r <= cctg_pkg::ADJ_RESET;
		end else if (apply_now && adj_pend_v_r) begin
			adj_r <= adj_pend_r;
		end
	end

	// System 780 clock divider; mck_rise marks the edge where it goes high.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			mck_cnt_r <= 8'h00;
			mck_r <= 1'b0;
		end else if (mck_cnt_r == 8'(MCK_HALF - 1)) begin
			mck_cnt_r <= 8'h00;
			mck_r <= ~mck_r;
		end else begin
			mck_cnt_r <= mck_cnt_r + 8'h01;
		end
	end
	assign mck_rise = (mck_cnt_r == 8'(MCK_HALF - 1)) & ~mck_r;

	// RQ7 capture on 780 rise.
	// Sync inputs are taken on the 780 clock rise and edges flagged once.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			hs_cap_r <= 1'b0;
			vs_cap_r <= 1'b0;
			hs_fall_r <= 1'b0;
			vs_fall_r <= 1'b0;
		end else begin
			hs_fall_r <= mck_rise & hs_cap_r & ~hs_s[1];
			vs_fall_r <= mck_rise & vs_cap_r & ~vs_s[1];
			if (mck_rise) begin
				hs_cap_r <= hs_s[1];
				vs_cap_r <= vs_s[1];
			end
		end
	end

	// RQ3 readout line tracking.
	// Lines counted from the vertical sync fall; one line is readout.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			line_r <= '0;
			readout_r <= 1'b0;
			post_r <= 1'b0;
		end else if (vs_fall_r) begin
			line_r <= '0;
			readout_r <= 1'b0;
			post_r <= 1'b0;
		end else if (hs_fall_r) begin
			line_r <= line_r + 1'b1;
			readout_r <= ((line_r + 1'b1) == LINE_W'(READOUT_LINE));
			post_r <= readout_r;
		end
	end

	// RQ6 even field detect.
	// RQ27 odd field detect.
	// Sample hsync a fixed delay after the vertical sync fall.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			fcnt_r <= '0;
			field_even_r <= 1'b0;
		end else if (vs_fall_r) begin
			fcnt_r <= cctg_pkg::FCNT_W'(cctg_pkg::FIELD_DLY_CYC);
		end else if (fcnt_r != '0) begin
			fcnt_r <= fcnt_r - 1'b1;
			if (fcnt_r == cctg_pkg::FCNT_W'(1)) begin
				field_even_r <= hs_s[1];
			end
		end
	end

	// Free-running dividers for the half-rate and DSP clocks.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			hrc_r <= 1'b0;
			dsp_r <= 1'b0;
			dsp_cnt_r <= 8'h00;
		end else begin
			if (mck_rise) begin
				hrc_r <= ~hrc_r;
			end
			if (dsp_cnt_r == 8'(DSP_HALF - 1)) begin
				dsp_cnt_r <= 8'h00;
				dsp_r <= ~dsp_r;
			end else begin
				dsp_cnt_r <= dsp_cnt_r + 8'h01;
			end
		end
	end

	// RQ10 outputs on 780 rise.
	// Write pulse and line tag move only when the 780 clock rises.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			write_pulse_out <= 1'b0;
			line_tag_out <= 1'b0;
		end else if (mck_rise) begin
			write_pulse_out <= ~ctl_r.write_pulse_off & hs_s[1];
			if (!ctl_r.line_tag_on) begin
				line_tag_out <= 1'b0;
			end else if (hs_cap_r && !hs_s[1]) begin
				line_tag_out <= ~line_tag_out;
			end
		end
	end

	// Clock outputs; the 780 clock is ungated, the syncs gated by sync_gen_on, the half-rate and DSP clocks by their enables and reset polarities.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sys_clock_780 <= 1'b0;
			hsync_out <= 1'b0;
			vsync_out <= 1'b0;
			half_rate_pixel_clock <= 1'b0;
			dsp_clock_1170 <= 1'b0;
		end else begin
			sys_clock_780 <= mck_r ^ (mck_cnt_r == 8'(MCK_HALF - 1));
			hsync_out <= ctl_r.sync_gen_on & hs_cap_r;
			vsync_out <= ctl_r.sync_gen_on & vs_cap_r;
			half_rate_pixel_clock <= ctl_r.half_rate_clock_on &
				(hrc_r ^ ctl_r.half_rate_reset_pol);
			dsp_clock_1170 <= ~ctl_r.dsp_clock_off &
				(dsp_r ^ ~ctl_r.dsp_clock_reset_pol);
		end
	end

	// RQ8 gate forces low.
	// A low drive gate zeroes the sensor, sample and converter pulses.
	assign gate_off = ~dg_s[1];
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			horiz_clock_a <= 1'b0;
			horiz_clock_b <= 1'b0;
			reset_gate_pulse <= 1'b0;
			precharge_sample_pulse <= 1'b0;
			level_sample_pulse <= 1'b0;
			adc_phase_sample <= 1'b0;
			adc_clock_out <= 1'b0;
			blanking_pulse <= 1'b0;
			black_clamp_pulse <= 1'b0;
			dummy_clamp_pulse <= 1'b0;
		end else begin
			horiz_clock_a <= ~gate_off & mck_r;
			horiz_clock_b <= ~gate_off & ~mck_r;
			reset_gate_pulse <= ~gate_off & mck_rise;
			precharge_sample_pulse <= ~gate_off & mck_r;
			level_sample_pulse <= ~gate_off & ~mck_r;
			adc_phase_sample <= ~gate_off & mck_r;
			adc_clock_out <= ~gate_off & mck_r;
			blanking_pulse <= ~gate_off & ~hs_cap_r;
			black_clamp_pulse <= ~gate_off & ctl_r.black_clamp_on & ~hs_cap_r;
			dummy_clamp_pulse <= ~gate_off & ~hs_cap_r;
		end
	end

	// RQ9 gate rail levels.
	// Vertical and substrate levels; readout line drives 2a/2b high.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			vert_clock_2a <= cctg_pkg::CCTG_LVL_LOW;
			vert_clock_2b <= cctg_pkg::CCTG_LVL_LOW;
			vert_clock_1 <= cctg_pkg::CCTG_LVL_LOW;
			vert_clock_3 <= cctg_pkg::CCTG_LVL_LOW;
			substrate_pulse <= cctg_pkg::CCTG_LVL_LOW;
		end else if (gate_off) begin
			vert_clock_2a <= cctg_pkg::CCTG_LVL_HIGH;
			vert_clock_2b <= cctg_pkg::CCTG_LVL_HIGH;
			vert_clock_1 <= cctg_pkg::CCTG_LVL_MID;
			vert_clock_3 <= cctg_pkg::CCTG_LVL_MID;
			substrate_pulse <= cctg_pkg::CCTG_LVL_HIGH;
		end else begin
			vert_clock_2a <= readout_r ? cctg_pkg::CCTG_LVL_HIGH : cctg_pkg::CCTG_LVL_LOW;
			vert_clock_2b <= readout_r ? cctg_pkg::CCTG_LVL_HIGH : cctg_pkg::CCTG_LVL_LOW;
			vert_clock_1 <= cctg_pkg::CCTG_LVL_LOW;
			vert_clock_3 <= cctg_pkg::CCTG_LVL_LOW;
			substrate_pulse <= (post_r & ctl_r.record_exposure_en) ?
				cctg_pkg::CCTG_LVL_HIGH : cctg_pkg::CCTG_LVL_LOW;
		end
	end
endmodule : cctg_top

// [verif/cctg_top_assertions.sv]
// Purpose: Concurrent checks on the control-word receiver's top-level ports.
// Assumes: All watched ports belong to clk, with rst_n active low.
// Notes: Gate checks leave room for the input synchronisers, enable checks for the next 780 clock rise.
`timescale 1ns/1ps
module cctg_chk (
	// Clock and reset.
	input wire logic clk,
	input wire logic rst_n,
	// Inputs watched.
	input wire logic drive_gate_in,
	// Clock and line outputs.
	input wire logic sys_clock_780,
	input wire logic hsync_out,
	input wire logic vsync_out,
	input wire logic dsp_clock_1170,
	input wire logic adc_clock_out,
	input wire logic write_pulse_out,
	input wire logic line_tag_out,
	input wire logic black_clamp_pulse,
	input wire logic blanking_pulse,
	input wire logic dummy_clamp_pulse,
	input wire logic half_rate_pixel_clock,
	// Sensor drive outputs.
	input wire logic horiz_clock_a,
	input wire logic horiz_clock_b,
	input wire logic reset_gate_pulse,
	input wire logic precharge_sample_pulse,
	input wire logic level_sample_pulse,
	input wire logic adc_phase_sample,
	input wire cctg_pkg::cctg_lvl_e vert_clock_2a,
	input wire cctg_pkg::cctg_lvl_e vert_clock_2b,
	input wire cctg_pkg::cctg_lvl_e vert_clock_1,
	input wire cctg_pkg::cctg_lvl_e vert_clock_3,
	input wire cctg_pkg::cctg_lvl_e substrate_pulse,
	// Register state.
	input wire cctg_pkg::cctg_ctl_s ctl_r,
	input wire logic [cctg_pkg::ADJ_W-1:0] adj_r,
	input wire logic field_even_r,
	input wire logic readout_r
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	logic [2:0] up_r;
	logic [2:0] low_r;
	logic [2:0] hi_r;
	logic [2:0] ro_age_r;
	logic mck_d_r;
	// Ages of reset release, of the gate level and of the last readout line.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			up_r <= 3'h0;
			low_r <= 3'h0;
			hi_r <= 3'h0;
			ro_age_r <= 3'h7;
		end else begin
			up_r <= (up_r == 3'h7) ? up_r : up_r + 3'h1;
			low_r <= drive_gate_in ? 3'h0 : ((low_r == 3'h7) ? low_r : low_r + 3'h1);
			hi_r <= !drive_gate_in ? 3'h0 : ((hi_r == 3'h7) ? hi_r : hi_r + 3'h1);
			ro_age_r <= readout_r ? 3'h0 : ((ro_age_r == 3'h7) ? ro_age_r : ro_age_r + 3'h1);
		end
	end
	// Level of the 780 clock one cycle back.
	always_ff @(posedge clk)
		mck_d_r <= sys_clock_780;
	AST_GATE_PULSES: assert property (low_r >= 3'h5 && up_r == 3'h7 |->
		!(horiz_clock_a | horiz_clock_b | reset_gate_pulse | precharge_sample_pulse |
		level_sample_pulse | adc_phase_sample | blanking_pulse | black_clamp_pulse |
		adc_clock_out | dummy_clamp_pulse))
		else $error("drive pulse still active with gate low");
	AST_GATE_LEVELS: assert property (low_r >= 3'h5 && up_r == 3'h7 |->
		vert_clock_2a == cctg_pkg::CCTG_LVL_HIGH && vert_clock_2b == cctg_pkg::CCTG_LVL_HIGH &&
		substrate_pulse == cctg_pkg::CCTG_LVL_HIGH && vert_clock_1 == cctg_pkg::CCTG_LVL_MID &&
		vert_clock_3 == cctg_pkg::CCTG_LVL_MID) else $error("rail levels wrong with gate low");
	AST_READOUT_V2: assert property (hi_r == 3'h7 && readout_r && ro_age_r == 3'h0 |->
		vert_clock_2a == cctg_pkg::CCTG_LVL_HIGH && vert_clock_2b == cctg_pkg::CCTG_LVL_HIGH)
		else $error("readout line without vertical readout level");
	AST_APPLY_AT_READOUT: assert property ($changed(ctl_r.shutter_lines) ||
		$changed(ctl_r.drive_mode_sel) || $changed(adj_r) |-> ro_age_r <= 3'h4)
		else $error("settings applied away from the readout line");
	AST_WRITE_ON_MCK: assert property ($changed(write_pulse_out) |->
		sys_clock_780 || mck_d_r) else $error("write pulse moved off a 780 rise");
	AST_TAG_ON_MCK: assert property ($changed(line_tag_out) |->
		sys_clock_780 || mck_d_r) else $error("line tag moved off a 780 rise");
	AST_SYNC_OFF: assert property ((!ctl_r.sync_gen_on) [*6] |->
		!hsync_out && !vsync_out) else $error("sync outputs active while disabled");
	AST_TAG_OFF: assert property ((!ctl_r.line_tag_on) [*6] |->
		!line_tag_out) else $error("line tag active while disabled");
	AST_DSP_OFF: assert property (ctl_r.dsp_clock_off [*6] |->
		!dsp_clock_1170) else $error("dsp clock running while stopped");
	AST_WRITE_OFF: assert property (ctl_r.write_pulse_off [*6] |->
		!write_pulse_out) else $error("write pulse active while stopped");
	AST_HALF_OFF: assert property ((!ctl_r.half_rate_clock_on) [*6] |->
		!half_rate_pixel_clock) else $error("half-rate clock running while stopped");
	// Main scenarios reached.
	COV_READOUT: cover property ($rose(readout_r));
	COV_EVEN: cover property ($rose(field_even_r));
	COV_GATE: cover property (low_r == 3'h7);
endmodule : cctg_chk

// [verif/cctg_host_model.sv]
// Purpose: Host model shifting 72-bit words onto the serial link.
// Assumes: The 12 ns link clock runs only within a word.
// Notes: Once released, the data line shows the inverse of the last bit.
`timescale 1ns/1ps
module cctg_host_model (
	// Bench request.
	input wire logic [71:0] word,
	input wire logic go,
	output logic busy,
	// Serial link.
	output logic serial_clock,
	output logic serial_data_in,
	output logic serial_strobe
);
	// Idle link with strobe high and clock still.
	initial begin
		busy = 1'b0;
		serial_clock = 1'b0;
		serial_data_in = 1'b0;
		serial_strobe = 1'b1;
	end
	always @(posedge go) begin
		busy = 1'b1;
		#3 serial_strobe = 1'b0;
		for (int i = 0; i < 72; i++) begin
			serial_data_in = word[i];
			#6 serial_clock = 1'b1;
			#6 serial_clock = 1'b0;
		end
		#6 serial_strobe = 1'b1;
		serial_data_in = ~word[71];
		busy = 1'b0;
	end
endmodule : cctg_host_model

// [verif/testbench.sv]
// Purpose: Self-checking bench for the control-word receiver.
// Assumes: Inputs change at the falling clock edge.
// Notes: Frames are short; the readout line is line 4 after vsync falls.
`timescale 1ns/1ps
module testbench;
	localparam logic [7:0] SEL = 8'hc3; // Arbitrary select code with bits 0 and 7 set.
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic check_bypass_in = 1'b0;
	logic hsync_in = 1'b0;
	logic vsync_in = 1'b1;
	logic drive_gate_in = 1'b1;
	logic go = 1'b0;
	logic [71:0] word = '0;
	logic busy, serial_clock, serial_data_in, serial_strobe, field_even_r;
	cctg_pkg::cctg_lvl_e vert_clock_2a;
	cctg_pkg::cctg_ctl_s ctl_r, exp_c;
	logic [47:0] adj_r, exp_a;
	int err_count = 0;
	int n_tests = 0;
	// System clock, 25 ns.
	always #12.5 clk = ~clk;
	cctg_host_model host (.word, .go, .busy, .serial_clock, .serial_data_in, .serial_strobe);
	cctg_top #(.CHIP_SELECT(SEL)) dut (.clk, .rst_n, .serial_clock, .serial_data_in,
		.serial_strobe, .check_bypass_in, .hsync_in, .vsync_in, .drive_gate_in,
		.sys_clock_780(), .hsync_out(), .vsync_out(), .half_rate_pixel_clock(),
		.dsp_clock_1170(), .adc_clock_out(), .write_pulse_out(), .line_tag_out(),
		.black_clamp_pulse(), .dummy_clamp_pulse(), .blanking_pulse(), .horiz_clock_a(),
		.horiz_clock_b(), .reset_gate_pulse(), .precharge_sample_pulse(),
		.level_sample_pulse(), .adc_phase_sample(), .vert_clock_2a, .vert_clock_2b(),
		.vert_clock_1(), .vert_clock_3(), .substrate_pulse(), .ctl_r, .adj_r,
		.field_even_r, .readout_r());
	task automatic tick(input int n);
		repeat (n) @(negedge clk);
	endtask : tick
	// Prints the verdict and ends the run.
	task automatic summarize();
		if (err_count == 0 && n_tests > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : summarize
	task automatic cmp_ctl(input cctg_pkg::cctg_ctl_s got, input cctg_pkg::cctg_ctl_s e);
		n_tests++;
		if (got !== e) begin
			err_count++;
			$display("[ERR] %0t control fields %h, expected %h", $time, got, e);
		end
	endtask : cmp_ctl
	task automatic cmp_vec(input logic [47:0] got, input logic [47:0] e);
		n_tests++;
		if (got !== e) begin
			err_count++;
			$display("[ERR] %0t value %h, expected %h", $time, got, e);
		end
	endtask : cmp_vec
	// Builds a word whose nine bytes sum to zero.
	function automatic logic [71:0] mk(input logic [7:0] sel, input logic [55:0] mid);
		logic [7:0] s;
		s = sel;
		for (int i = 0; i < 7; i++)
			s += mid[i*8 +: 8];
		return {8'h00 - s, mid, sel};
	endfunction : mk
	// Control fields as they sit in the word, reserved bits dropped.
	function automatic cctg_pkg::cctg_ctl_s ctl_of(input logic [71:0] w);
		return {w[63:51], w[48], w[35:16]};
	endfunction : ctl_of
	// Shifts a word in and waits for the host to finish.
	task automatic send(input logic [71:0] w);
		int k;
		word = w;
		go = 1'b1;
		tick(1);
		go = 1'b0;
		for (k = 0; k < 100 && busy !== 1'b0; k++)
			tick(1);
		if (busy !== 1'b0) begin
			err_count++;
			$display("[ERR] %0t serial word never finished", $time);
			summarize();
		end
		tick(8);
	endtask : send
	// One field: hsync level at the field sample, then eight lines.
	task automatic frame(input logic ev);
		vsync_in = 1'b0;
		hsync_in = ev;
		tick(60);
		for (int i = 0; i < 8; i++) begin
			hsync_in = 1'b1;
			tick(20);
			hsync_in = 1'b0;
			tick(20);
		end
		vsync_in = 1'b1;
		tick(20);
	endtask : frame
	// Sends a word, checks the immediate fields, runs a field, checks the rest.
	task automatic try(input logic [71:0] w, input logic ok, input logic ev);
		send(w);
		if (ok && !w[8]) begin
			exp_c.sync_gen_on = w[52];
			exp_c.pin_state_ctl = w[63:62];
		end
		cmp_ctl(ctl_r, exp_c);
		frame(ev);
		if (ok && !w[8])
			exp_c = ctl_of(w);
		if (ok && w[8])
			exp_a = w[63:16];
		cmp_ctl(ctl_r, exp_c);
		cmp_vec(adj_r, exp_a);
		cmp_vec({47'h0, field_even_r}, {47'h0, ev});
	endtask : try
	// Main sequence.
	initial begin
		tick(10);
		rst_n = 1'b1;
		tick(2);
		exp_c = '0;
		exp_a = '0;
		cmp_ctl(ctl_r, exp_c);
		cmp_vec(adj_r, exp_a);
		try(mk(SEL, 56'h02d0_0000_0000_00), 1'b1, 1'b0);
		try(mk(SEL, 56'h9bf9_000b_1d6b_00), 1'b1, 1'b1);
		try(mk(SEL, 56'h0) ^ {8'h01, 64'h0}, 1'b0, 1'b0);
		try(mk(8'h41, 56'h0010_0000_0000_00), 1'b0, 1'b1);
		check_bypass_in = 1'b1;
		tick(4);
		try(mk(SEL, 56'h0) ^ {8'h01, 64'h0}, 1'b1, 1'b0);
		check_bypass_in = 1'b0;
		try(mk(SEL, 56'h1234_5678_9abc_01), 1'b1, 1'b1);
		drive_gate_in = 1'b0;
		tick(8);
		cmp_vec({46'h0, vert_clock_2a}, {46'h0, cctg_pkg::CCTG_LVL_HIGH});
		drive_gate_in = 1'b1;
		tick(6);
		summarize();
	end
endmodule : testbench
bind cctg_top cctg_chk chk (.*);
